// >>> src/reset_seq_pkg.sv
// Constants, states and the reset image for the chip reset sequencer
package reset_seq_pkg;

  localparam int CLK_PERIOD_NS    = 8;
  localparam int RELEASE_DELAY_NS = 5000;
  localparam int RELEASE_CYCLES   = (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DLY_W            = 10;
  localparam logic [DLY_W-1:0] DLY_LAST = DLY_W'(RELEASE_CYCLES - 1);
  localparam logic [DLY_W-1:0] DLY_ZERO = 10'h000;

  localparam logic [7:0]  OSC_SETTLE_SELECT_RST = 8'h05;
  localparam logic [7:0]  OSC_SETTLE_STATUS_RST = 8'h00;
  localparam logic [7:0]  PORT_LATCH_RST        = 8'h00;
  localparam logic [7:0]  PORT_DIRECTION_RST    = 8'hFF;
  localparam logic [7:0]  PULLUP_OPTION_RST     = 8'h00;
  localparam logic [15:0] WIDE_TIMER_WORD_RST   = 16'h0000;
  localparam logic [7:0]  WIDE_TIMER_CTL_RST    = 8'h00;
  localparam logic [15:0] PC_RST                = 16'h0000;

  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_HOLD  = 4'b0010,
    ST_DELAY = 4'b0100,
    ST_ACK   = 4'b1000
  } seq_state_t;

  typedef struct packed {
    logic [7:0]  osc_settle_select;
    logic [7:0]  osc_settle_status;
    logic [7:0]  port_latch;
    logic [7:0]  port_direction_regs;
    logic [7:0]  pullup_option_regs;
    logic [15:0] wide_timer_counter;
    logic [15:0] wide_timer_capcomp;
    logic [7:0]  wide_timer_mode_ctl;
    logic [7:0]  wide_timer_prescale;
    logic [7:0]  wide_timer_capcomp_ctl;
    logic [7:0]  wide_timer_output_ctl;
  } reset_image_t;

  localparam reset_image_t RESET_IMAGE = '{
    osc_settle_select:      OSC_SETTLE_SELECT_RST,
    osc_settle_status:      OSC_SETTLE_STATUS_RST,
    port_latch:             PORT_LATCH_RST,
    port_direction_regs:    PORT_DIRECTION_RST,
    pullup_option_regs:     PULLUP_OPTION_RST,
    wide_timer_counter:     WIDE_TIMER_WORD_RST,
    wide_timer_capcomp:     WIDE_TIMER_WORD_RST,
    wide_timer_mode_ctl:    WIDE_TIMER_CTL_RST,
    wide_timer_prescale:    WIDE_TIMER_CTL_RST,
    wide_timer_capcomp_ctl: WIDE_TIMER_CTL_RST,
    wide_timer_output_ctl:  WIDE_TIMER_CTL_RST
  };

endpackage

// >>> src/chip_reset_sequencer.sv
// Reset sequencer: merges reset sources, gates clocks, releases and loads reset state
// Notes on behaviour
// - CPU clock gated off throughout reset
// - Both crystal oscillators halted, pins become ports
// - External clock inputs ignored during reset
// - Program counter loaded from reset vector word
// - Settle select register set to default code
// - Settle status register cleared on acknowledge
// - Port output latches cleared on acknowledge
// - Port direction registers set to all inputs
// - Pull-up option registers cleared on acknowledge
// - Wide timer counters and capture registers cleared
// - Wide timer control registers cleared on acknowledge
// - CPU restarts on internal oscillator; crystal waits
// - Watchdog reset also resets the watchdog
// - Low-voltage reset leaves detector itself untouched
// - Four sources; watchdog and low-voltage resets differ in watchdog and detector reset
module chip_reset_sequencer (
  input  wire logic                        mclk,
  input  wire logic                        resetn,
  input  wire logic                        ext_reset_pin_n,
  input  wire logic                        wdt_overflow,
  input  wire logic                        power_on_clear_circuit_trip,
  input  wire logic                        low_voltage_detector_trip,
  input  wire logic [7:0]                  vector_lo,
  input  wire logic [7:0]                  vector_hi,
  input  wire logic                        sw_main_osc_start,
  input  wire logic                        sw_sub_osc_start,
  input  wire logic                        sw_ext_clk_enable,
  input  wire logic                        sw_cpu_clk_main,
  output logic                             sys_reset_n,
  output logic                             cpu_clk_en,
  output logic                             cpu_on_internal_osc,
  output logic                             main_osc_run,
  output logic                             sub_osc_run,
  output logic                             osc_pins_port_mode,
  output logic                             ext_clk_accept,
  output logic                             port_hiz,
  output logic                             pc_load,
  output logic [15:0]                      pc,
  output reset_seq_pkg::reset_image_t      reset_image,
  output logic                             image_load,
  output logic                             wdt_reset,
  output logic                             lvi_block_reset
);
  import reset_seq_pkg::*;

  logic              ext_s1_reg;
  logic              ext_s2_reg;
  logic              poc_s1_reg;
  logic              poc_s2_reg;
  logic              lvi_s1_reg;
  logic              lvi_s2_reg;
  logic              ext_req;
  logic              other_req;
  logic              any_req;
  logic [15:0]       vector_word;
  seq_state_t        state_reg;
  seq_state_t        state_next;
  logic [DLY_W-1:0]  dly_cnt_reg;
  logic              wdt_cause_reg;
  logic              in_run_next;

  // Second stage alone feeds logic, so a late pin edge cannot glitch the release
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_reset_pin_n;
      ext_s2_reg <= ext_s1_reg;
    end
  end

  // Detector comparators are analog and asynchronous to mclk
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      poc_s1_reg <= 1'b0;
      poc_s2_reg <= 1'b0;
      lvi_s1_reg <= 1'b0;
      lvi_s2_reg <= 1'b0;
    end else begin
      poc_s1_reg <= power_on_clear_circuit_trip;
      poc_s2_reg <= poc_s1_reg;
      lvi_s1_reg <= low_voltage_detector_trip;
      lvi_s2_reg <= lvi_s1_reg;
    end
  end

  assign ext_req     = !ext_s2_reg;
  assign other_req   = ext_req | wdt_overflow | poc_s2_reg;
  assign any_req     = other_req | lvi_s2_reg;
  assign vector_word = {vector_hi, vector_lo};

  always_comb begin
    state_next = state_reg;
    if (any_req) begin
      state_next = ST_HOLD;
    end else begin
      case (state_reg)
        ST_HOLD:  state_next = ST_DELAY;
        ST_DELAY: state_next = (dly_cnt_reg == DLY_LAST) ? ST_ACK : ST_DELAY;
        ST_ACK:   state_next = ST_RUN;
        ST_RUN:   state_next = ST_RUN;
        default:  state_next = ST_HOLD;
      endcase
    end
  end

  assign in_run_next = (state_next == ST_RUN);

  // Power-up passes through the same release delay as any other reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg <= ST_DELAY;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      dly_cnt_reg <= DLY_ZERO;
    end else if (state_next != ST_DELAY || state_reg != ST_DELAY) begin
      dly_cnt_reg <= DLY_ZERO;
    end else begin
      dly_cnt_reg <= dly_cnt_reg + 10'h001;
    end
  end

  // Outputs follow the next state so they line up with state_reg
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sys_reset_n        <= 1'b0;
      cpu_clk_en         <= 1'b0;
      port_hiz           <= 1'b1;
      ext_clk_accept     <= 1'b0;
      osc_pins_port_mode <= 1'b1;
    end else begin
      sys_reset_n        <= in_run_next;
      cpu_clk_en         <= in_run_next;
      port_hiz           <= !in_run_next && state_next != ST_ACK;
      ext_clk_accept     <= in_run_next && sw_ext_clk_enable;
      osc_pins_port_mode <= !(in_run_next && (sw_main_osc_start || sw_sub_osc_start));
    end
  end

  // Crystals stay stopped after release until software asks for them
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      main_osc_run        <= 1'b0;
      sub_osc_run         <= 1'b0;
      cpu_on_internal_osc <= 1'b1;
    end else if (!in_run_next) begin
      main_osc_run        <= 1'b0;
      sub_osc_run         <= 1'b0;
      cpu_on_internal_osc <= 1'b1;
    end else begin
      main_osc_run        <= sw_main_osc_start;
      sub_osc_run         <= sw_sub_osc_start;
      cpu_on_internal_osc <= !(sw_cpu_clk_main && main_osc_run);
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pc         <= PC_RST;
      pc_load    <= 1'b0;
      image_load <= 1'b0;
      reset_image <= RESET_IMAGE;
    end else begin
      pc_load    <= (state_reg == ST_ACK);
      image_load <= (state_reg == ST_ACK);
      if (state_reg == ST_ACK) begin
        pc          <= vector_word;
        reset_image <= RESET_IMAGE;
      end
    end
  end

  // Cause is sticky across the reset; a new overflow wins over the clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wdt_cause_reg <= 1'b0;
    end else if (wdt_overflow) begin
      wdt_cause_reg <= 1'b1;
    end else if (state_reg == ST_ACK) begin
      wdt_cause_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wdt_reset       <= 1'b1;
      lvi_block_reset <= 1'b1;
    end else begin
      wdt_reset       <= wdt_overflow || (wdt_cause_reg && state_reg != ST_ACK);
      lvi_block_reset <= other_req;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  cpu_clk_gate_a: assert property (any_req |=> !cpu_clk_en && !sys_reset_n)
    else $error("cpu clock running during reset");
  osc_halt_a: assert property (any_req |=> !main_osc_run && !sub_osc_run && osc_pins_port_mode)
    else $error("oscillator active during reset");
  ext_clk_ignore_a: assert property (any_req |=> !ext_clk_accept)
    else $error("external clock accepted during reset");
  pc_vector_load_a: assert property (pc_load |-> pc == $past(vector_word))
    else $error("pc not loaded from vector");
  image_defaults_a: assert property (image_load |-> reset_image == RESET_IMAGE && pc_load)
    else $error("reset image wrong on acknowledge");
  release_delay_a: assert property (state_reg == ST_ACK |-> $past(dly_cnt_reg) == DLY_LAST)
    else $error("release before fixed delay");
  port_hiz_a: assert property (any_req |=> port_hiz [*1] ##1 (port_hiz || !any_req))
    else $error("ports driven during reset");
  internal_osc_start_a: assert property (pc_load |-> cpu_clk_en && cpu_on_internal_osc)
    else $error("cpu not on internal oscillator after reset");
  wdt_self_reset_a: assert property (wdt_overflow |=> wdt_reset)
    else $error("watchdog not reset by its overflow");
  lvi_untouched_a: assert property (lvi_s2_reg && !other_req |=> !lvi_block_reset)
    else $error("detector reset by its own request");
  sync_release_a: assert property ($rose(ext_s2_reg) && !other_req && !lvi_s2_reg
                                   |-> !cpu_clk_en [*8])
    else $error("release too soon after pin rise");

endmodule

// >>> verif/reset_source_model.sv
// Behavioural model of the external reset pin driver and on-chip reset sources
module reset_source_model #(
  parameter int MIN_LOW_CYC = 1250
) (
  input  wire logic       mclk,
  input  wire logic [1:0] kind,
  input  wire logic       active,
  output logic            pin_n,
  output logic            wdt,
  output logic            power_on_clear_circuit,
  output logic            low_voltage_detector
);
  timeunit 1ns;
  timeprecision 1ps;
  int   low_cnt  = 0;
  logic active_q = 1'b0;
  logic wdt_q    = 1'b0;
  logic poc_q    = 1'b0;
  logic lvi_q    = 1'b0;
  always @(posedge mclk) begin
    active_q <= active;
    // Watchdog overflow is a single-cycle pulse
    wdt_q    <= active && !active_q && kind == 2'd1;
    poc_q    <= active && kind == 2'd2;
    lvi_q    <= active && kind == 2'd3;
    // Pin held low for MIN_LOW_CYC more cycles after the request drops, never shorter
    if (active && kind == 2'd0) begin
      low_cnt <= MIN_LOW_CYC;
    end else if (low_cnt > 0) begin
      low_cnt <= low_cnt - 1;
    end
  end
  // Pin has a pull-up, so it reads high once released
  assign pin_n = !((active && kind == 2'd0) || low_cnt > 0);
  assign wdt   = wdt_q;
  assign power_on_clear_circuit   = poc_q;
  assign low_voltage_detector   = lvi_q;
endmodule

// >>> verif/testbench.sv
// Self-checking bench for the chip reset sequencer
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got %0h exp %0h", $time, (a), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import reset_seq_pkg::*;
  typedef struct packed {
    logic [1:0]  kind;
    logic        exp_lvi;
    logic [15:0] vec;
  } row_t;
  localparam row_t ROWS [4] = '{'{2'd0, 1'b1, 16'h1234}, '{2'd1, 1'b1, 16'hA55A},
                                '{2'd2, 1'b1, 16'h0FF0}, '{2'd3, 1'b0, 16'hFFFF}};
  logic mclk = 1'b0, resetn = 1'b0, active = 1'b0, sw = 1'b0;
  logic [1:0] kind = 2'd0;
  logic [7:0] vector_lo = 8'hC3, vector_hi = 8'h00;
  logic pin_n, wdt, power_on_clear_circuit, low_voltage_detector, sys_reset_n, cpu_clk_en, cpu_on_internal_osc, main_osc_run;
  logic sub_osc_run, osc_pins_port_mode, ext_clk_accept, port_hiz, pc_load, image_load;
  logic wdt_reset, lvi_block_reset;
  logic [15:0] pc;
  reset_image_t reset_image;
  int num_errors = 0, n_checks = 0, cnt;
  reset_source_model src (.mclk, .kind, .active, .pin_n, .wdt, .power_on_clear_circuit, .low_voltage_detector);
  chip_reset_sequencer dut (.mclk, .resetn, .ext_reset_pin_n(pin_n), .wdt_overflow(wdt),
    .power_on_clear_circuit_trip(power_on_clear_circuit), .low_voltage_detector_trip(low_voltage_detector), .vector_lo,
    .vector_hi, .sw_main_osc_start(sw), .sw_sub_osc_start(sw), .sw_ext_clk_enable(sw),
    .sw_cpu_clk_main(sw), .sys_reset_n, .cpu_clk_en, .cpu_on_internal_osc, .main_osc_run,
    .sub_osc_run, .osc_pins_port_mode, .ext_clk_accept, .port_hiz, .pc_load, .pc,
    .reset_image, .image_load, .wdt_reset, .lvi_block_reset);
  initial begin
    forever #4 mclk = ~mclk;
  end
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Waits out the sources, then measures the release delay up to the load pulse
  task automatic finish_release(logic [15:0] v);
    cnt = 0;
    while ((!pin_n || wdt || power_on_clear_circuit || low_voltage_detector) && cnt < 3000) begin
      step(1);
      cnt++;
    end
    cnt = 0;
    while (pc_load !== 1'b1 && cnt < 1000) begin
      step(1);
      cnt++;
    end
    `CHK(cnt >= RELEASE_CYCLES && cnt <= RELEASE_CYCLES + 8, 1'b1)
    `CHK(pc, v)
    `CHK(reset_image, RESET_IMAGE)
    `CHK({image_load, sys_reset_n, cpu_clk_en, port_hiz}, 4'hE)
    `CHK({cpu_on_internal_osc, main_osc_run, sub_osc_run}, {1'b1, sw, sw})
    `CHK({ext_clk_accept, osc_pins_port_mode}, {sw, !sw})
    `CHK(reset_image.port_latch[0], 1'b0)
    step(1);
    `CHK(pc_load, 1'b0)
    step(2);
    `CHK({cpu_on_internal_osc, main_osc_run}, {!sw, sw})
  endtask
  task automatic run_reset(row_t r, logic mid);
    kind = r.kind;
    {vector_hi, vector_lo} = r.vec;
    active = 1'b1;
    step(1);
    active = 1'b0;
    cnt = 0;
    while (sys_reset_n !== 1'b0 && cnt < 10) begin
      step(1);
      cnt++;
    end
    // Detector reset follows the request itself, so look where reset begins
    `CHK(lvi_block_reset, r.exp_lvi)
    step(2);
    `CHK({cpu_clk_en, port_hiz}, 2'b01)
    `CHK({main_osc_run, sub_osc_run, osc_pins_port_mode}, 3'b001)
    `CHK(ext_clk_accept, 1'b0)
    if (r.kind == 2'd1) `CHK(wdt_reset, 1'b1)
    if (mid) begin
      while (!pin_n) step(1);
      step(100);
      kind = 2'd1;
      active = 1'b1;
      step(1);
      active = 1'b0;
      step(2);
      `CHK({sys_reset_n, wdt_reset}, 2'b01)
    end
    finish_release(r.vec);
  endtask
  initial begin
    step(4);
    `CHK({sys_reset_n, cpu_clk_en, port_hiz, wdt_reset}, 4'h3)
    resetn = 1'b1;
    finish_release(16'h00C3);
    // Software starts the crystal and moves the CPU onto it
    sw = 1'b1;
    step(2);
    `CHK({cpu_on_internal_osc, main_osc_run, ext_clk_accept}, 3'b011)
    foreach (ROWS[i]) run_reset(ROWS[i], 1'b0);
    // Restart of the release delay by a late watchdog request
    run_reset('{2'd0, 1'b1, 16'h5A00}, 1'b1);
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    print_verdict();
  end
endmodule
